// File: dv/cfg_prog.sv
`timescale 1ns/1ps
module cfg_prog (
	input wire mclk,
	input wire go,
	input wire [8:0] fld,
	output reg cfg_load = 1'h0,
	output reg [31:0] cfg_data = 32'h0
);
always @(posedge mclk) begin
	cfg_load <= go;
	cfg_data <= go ? {6'h3f, fld[8:5], 1'h1, fld[4:0], 16'hffff} : ~cfg_data;
end
endmodule // cfg_prog

// File: dv/test_watchdog_config_decode.sv
`timescale 1ns/1ps
module test_watchdog_config_decode;
reg mclk = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, go = 1'h0, er;
reg [31:0] paddr = 32'h0, pwdata = 32'h0, rd;
reg [8:0] fld = 9'h0;
wire cfg_load, pready, pslverr, wdt_timeout, wdt_window_fault, wdt_running;
wire [31:0] cfg_data, prdata;
integer error_cnt = 0, comparisons = 0, cyc = 0, nf = 0, tl = 0, gap = 0, i, k;
always #12.5 mclk = ~mclk;
cfg_prog prog(.mclk(mclk), .go(go), .fld(fld), .cfg_load(cfg_load), .cfg_data(cfg_data));
watchdog_config_decode #(.TICK_DIV(4)) dut(
	.mclk(mclk), .rst(rst), .cfg_load(cfg_load), .cfg_data(cfg_data),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .wdt_timeout(wdt_timeout),
	.wdt_window_fault(wdt_window_fault), .wdt_running(wdt_running)
);
always @(posedge mclk) begin
	cyc <= cyc + 1;
	nf <= nf + wdt_window_fault;
	if (wdt_timeout) begin
		tl <= cyc;
		gap <= cyc - tl;
	end
	if (cyc > 20000) begin
		error_cnt = error_cnt + 1;
		final_report;
	end
end
task chk(input [47:0] nm, input [31:0] got, exp);
	comparisons = comparisons + 1;
	if (got !== exp) begin
		error_cnt = error_cnt + 1;
		$display("mismatch %0s exp %h got %h", nm, exp, got);
	end
endtask
task apb(input w, input [31:0] a, d);
	psel <= 1'h1;
	pwrite <= w;
	paddr <= a;
	pwdata <= d;
	@(posedge mclk) penable <= 1'h1;
	do @(posedge mclk); while (pready !== 1'h1);
	rd = prdata;
	er = pslverr;
	psel <= 1'h0;
	penable <= 1'h0;
	@(posedge mclk);
endtask
task ld(input [8:0] f);
	go <= 1'h1;
	fld <= f;
	@(posedge mclk) go <= 1'h0;
	repeat (3) @(posedge mclk);
endtask
task t_fuse;
	ld(9'h1c0);
	apb(0, 0, 0);
	chk("cfg", rd, 32'hffa0ffff);
	apb(1, 0, 0);
	apb(1, 4, 0);
	apb(0, 0, 0);
	chk("cfg", rd, 32'hffa0ffff);
	chk("run", wdt_running, 1);
	apb(0, 8, 0);
	chk("stat", rd[3:0], 4'hb);
	apb(0, 12, 0);
	chk("err", {er, rd[30:0]}, 32'h80000000);
endtask
task t_ratio;
	for (i = 0; i < 4; i = i + 1) begin
		ld({4'hf, i[4:0]});
		repeat ((12 << i) + 8) @(posedge mclk);
		chk("gap", gap, 4 << i);
	end
	for (i = 0; i < 32; i = i + 1) begin
		ld({4'hf, i[4:0]});
		apb(0, 8, 0);
		chk("ps", rd[20:16], i > 20 ? 20 : i);
	end
endtask
task t_win;
	for (i = 0; i < 4; i = i + 1) begin
		ld({i[1:0], 7'h44});
		apb(1, 4, 2);
		repeat (i == 0 ? 8 : 16 + 8 * i) @(posedge mclk);
		k = nf;
		apb(1, 4, 2);
		repeat (i == 0 ? 14 : 22 + 8 * i) @(posedge mclk);
		chk("early", nf - k, 1);
		k = nf;
		apb(1, 4, 2);
		repeat (2) @(posedge mclk);
		chk("late", nf - k, 0);
	end
	ld(9'h1e4);
	k = nf;
	apb(1, 4, 2);
	apb(1, 4, 2);
	repeat (2) @(posedge mclk);
	chk("nowin", nf - k, 0);
endtask
task t_soft;
	ld(9'h1a4);
	chk("stop", wdt_running, 0);
	apb(1, 4, 1);
	repeat (2) @(posedge mclk);
	chk("start", wdt_running, 1);
	apb(0, 4, 0);
	chk("ctrl", rd, 32'h1);
	apb(0, 8, 0);
	chk("wflt", rd[2], 1);
	apb(1, 8, 4);
	apb(0, 8, 0);
	chk("wclr", rd[2], 0);
endtask
task final_report;
	if (error_cnt == 0 && comparisons > 0)
		$display("Result: passed");
	else
		$display("Result: failed");
	$finish;
endtask
initial begin
	repeat (20) @(posedge mclk);
	rst <= 1'h0;
	apb(0, 0, 0);
	chk("rst", rd, 32'hffffffff);
	t_fuse;
	t_ratio;
	t_win;
	t_soft;
	final_report;
end
endmodule // test_watchdog_config_decode
bind watchdog_config_decode wdt_cfg_chk mon(
	.mclk(mclk), .rst(rst), .cfg_load(cfg_load), .cfg_data(cfg_data),
	.psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .wdt_timeout(wdt_timeout),
	.wdt_window_fault(wdt_window_fault), .wdt_running(wdt_running)
);

// File: dv/wdt_cfg_chk_assertions.sv
`timescale 1ns/1ps
module wdt_cfg_chk (
	input wire mclk,
	input wire rst,
	input wire cfg_load,
	input wire [31:0] cfg_data,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	input wire wdt_timeout,
	input wire wdt_window_fault,
	input wire wdt_running
);
default clocking @(posedge mclk); endclocking
default disable iff (rst);
chk_ready_pulse: assert property (pready |=> !pready) else $error("ready");
chk_err_read: assert property (pslverr |-> pready && (pwrite || prdata == 0)) else $error("err");
chk_one_wait: assert property (psel && $rose(penable) |=> pready) else $error("wait");
chk_fuse_run: assert property (cfg_load && cfg_data[23] |-> ##[1:2] wdt_running) else $error("fuse");
chk_tmo_pulse: assert property (wdt_timeout |=> !wdt_timeout) else $error("tmo");
chk_tmo_run: assert property (wdt_timeout |-> $past(wdt_running)) else $error("idle");
chk_flt_pulse: assert property (wdt_window_fault |=> !wdt_window_fault) else $error("flt");
chk_flt_kick: assert property (wdt_window_fault |-> $past(pready && pwrite)) else $error("kick");
endmodule // wdt_cfg_chk

// File: rtl/tick_divider.v
`timescale 1ns/1ps
module tick_divider #(
	parameter DIV = 40,
	parameter W = 16
) (
	input wire mclk,
	input wire rst,
	input wire run,
	output reg tick
);
	localparam [W-1:0] LAST = DIV - 1;
	reg [W-1:0] cnt_reg;
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			cnt_reg <= {W{1'b0}};
			tick <= 1'b0;
		end else if (!run) begin
			cnt_reg <= {W{1'b0}};
			tick <= 1'b0;
		end else if (cnt_reg == LAST) begin
			cnt_reg <= {W{1'b0}};
			tick <= 1'b1;
		end else begin
			cnt_reg <= cnt_reg + 1'b1;
			tick <= 1'b0;
		end
	end
endmodule // tick_divider

// File: rtl/watchdog_config_decode.v
// Local design decisions: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`include "wdt_cfg_map.vh"
module watchdog_config_decode #(
	parameter TICK_DIV = `TICK_CYCLES
) (
	input wire mclk,
	input wire rst,
	input wire cfg_load,
	input wire [31:0] cfg_data,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	output reg wdt_timeout,
	output reg wdt_window_fault,
	output reg wdt_running
);
	reg [31:0] config_word_one;
	reg cfg_valid_reg;
	reg sw_en_reg;
	reg timeout_reg;
	reg wfault_reg;
	reg [20:0] count_reg;
	wire tick;
	wire [1:0] wdt_window_size_sel = config_word_one[`WIN_SZ_HI:`WIN_SZ_LO];
	wire wdt_fuse_enable = config_word_one[`FUSE_EN_BIT];
	wire window_mode_disable = config_word_one[`WIN_DIS_BIT];
	wire [4:0] wdt_postscale_sel = config_word_one[`PS_HI:`PS_LO];
	wire [4:0] ps_eff;
	wire [20:0] ratio;
	reg [20:0] open_at;
	wire run;
	wire acc;
	wire wr;
	wire kick;
	wire mapped;
	wire expire;
	wire early;
	wire sel_config;
	wire sel_ctrl;
	wire sel_status;
	wire ctrl_wr;
	wire status_wr;
	wire clr_timeout;
	wire clr_wfault;
	wire count_restart;
	wire fuse_run;
	wire soft_run;
	wire [20:0] ratio_half;
	wire [20:0] ratio_quarter;
	wire [20:0] ratio_eighth;
	wire [20:0] last_count;
	reg [31:0] ctrl_word;
	reg [31:0] status_word;
	reg [31:0] rdata_next;
	reg err_next;
	reg timeout_next;
	reg wfault_next;

	assign ps_eff = (wdt_postscale_sel > `PS_MAX) ? `PS_MAX : wdt_postscale_sel;
	assign ratio = 21'h000001 << ps_eff;
	assign last_count = ratio - 21'h000001;
	assign ratio_half = ratio >> `OPEN_H_SHIFT;
	assign ratio_quarter = ratio >> `OPEN_Q_SHIFT;
	assign ratio_eighth = ratio >> `OPEN_E_SHIFT;
	// fuse forces run regardless of the software bit
	assign fuse_run = cfg_valid_reg & wdt_fuse_enable;
	assign soft_run = cfg_valid_reg & sw_en_reg;
	assign run = fuse_run | soft_run;

	// first count at which a clear is legal in window mode
	always @* begin
		case (wdt_window_size_sel)
		`WIN_25: open_at = ratio_quarter * `OPEN_25_MUL;
		`WIN_37: open_at = ratio_eighth * `OPEN_37_MUL;
		`WIN_50: open_at = ratio_half;
		`WIN_75: open_at = ratio_quarter;
		default: open_at = 21'h0;
		endcase
	end

	assign acc = psel & penable & pready;
	assign wr = acc & pwrite;
	assign sel_config = (paddr[`ADDR_BITS-1:0] == `ADDR_CONFIG);
	assign sel_ctrl = (paddr[`ADDR_BITS-1:0] == `ADDR_CTRL);
	assign sel_status = (paddr[`ADDR_BITS-1:0] == `ADDR_STATUS);
	assign mapped = sel_config | sel_ctrl | sel_status;
	// no bus write path to the config word
	assign ctrl_wr = wr & sel_ctrl;
	assign status_wr = wr & sel_status;
	assign clr_timeout = status_wr & pwdata[`ST_TIMEOUT];
	assign clr_wfault = status_wr & pwdata[`ST_WFAULT];
	assign kick = ctrl_wr & pwdata[`CTRL_KICK];
	assign count_restart = !run | kick | expire;
	// >= also ends a count left above a smaller reloaded ratio
	assign expire = run & tick & (count_reg >= last_count);
	assign early = run & kick & !window_mode_disable & (count_reg < open_at);

	tick_divider #(
		.DIV(TICK_DIV),
		.W(`DIV_W)
	) u_tick (
		.mclk(mclk),
		.rst(rst),
		.run(run),
		.tick(tick)
	);

	// config word changes only by a programming load
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			config_word_one <= `CFG_RESET;
			cfg_valid_reg <= 1'b0;
		end else if (cfg_load) begin
			config_word_one <= cfg_data;
			cfg_valid_reg <= 1'b1;
		end
	end

	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			sw_en_reg <= 1'b0;
		end else if (ctrl_wr) begin
			sw_en_reg <= pwdata[`CTRL_SW_EN];
		end
	end

	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			count_reg <= 21'h0;
		end else if (count_restart) begin
			count_reg <= 21'h0;
		end else if (tick) begin
			count_reg <= count_reg + 21'h1;
		end
	end

	// a new event wins over a write-one clear
	always @* begin
		timeout_next = timeout_reg;
		if (clr_timeout) begin
			timeout_next = 1'b0;
		end
		if (expire) begin
			timeout_next = 1'b1;
		end
	end

	always @* begin
		wfault_next = wfault_reg;
		if (clr_wfault) begin
			wfault_next = 1'b0;
		end
		if (early) begin
			wfault_next = 1'b1;
		end
	end

	// sticky status flags
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			timeout_reg <= 1'b0;
			wfault_reg <= 1'b0;
		end else begin
			timeout_reg <= timeout_next;
			wfault_reg <= wfault_next;
		end
	end

	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			wdt_timeout <= 1'b0;
			wdt_window_fault <= 1'b0;
			wdt_running <= 1'b0;
		end else begin
			wdt_timeout <= expire;
			wdt_window_fault <= early;
			wdt_running <= run;
		end
	end

	// register images as software reads them
	always @* begin
		ctrl_word = 32'h00000000;
		ctrl_word[`CTRL_SW_EN] = sw_en_reg;
	end

	always @* begin
		status_word = 32'h00000000;
		status_word[`ST_RUN] = run;
		status_word[`ST_TIMEOUT] = timeout_reg;
		status_word[`ST_WFAULT] = wfault_reg;
		status_word[`ST_CFG_VALID] = cfg_valid_reg;
		status_word[`ST_PS_HI:`ST_PS_LO] = ps_eff;
	end

	// unmapped offsets read zero and answer with an error
	always @* begin
		rdata_next = 32'h00000000;
		err_next = !mapped;
		case (paddr[`ADDR_BITS-1:0])
		`ADDR_CONFIG: rdata_next = config_word_one;
		`ADDR_CTRL: rdata_next = ctrl_word;
		`ADDR_STATUS: rdata_next = status_word;
		default: rdata_next = 32'h00000000;
		endcase
	end

	// apb: ready one cycle into the access phase
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else if (psel && penable && !pready) begin
			pready <= 1'b1;
			pslverr <= err_next;
			prdata <= rdata_next;
		end else begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
	end
endmodule // watchdog_config_decode

// File: rtl/wdt_cfg_map.vh
// What this block does
// - window size codes 11/10/01/00 give 25/37.5/50/75%
// - fuse enable set: runs after a programming load, software cannot stop
// - fuse enable clear: stopped, software may start
// - window disable 1 non-window, 0 window
// - postscale ratio is two to the code
// - codes above 10100 act as 10100
// - fields at 25:24, 23, 22, 20:16
// - fields readable, set only by programming
`ifndef WDT_CFG_MAP_VH
`define WDT_CFG_MAP_VH
`define ADDR_CONFIG 12'h000
`define ADDR_CTRL 12'h004
`define ADDR_STATUS 12'h008
`define ADDR_BITS 12
`define WIN_SZ_HI 25
`define WIN_SZ_LO 24
`define FUSE_EN_BIT 23
`define WIN_DIS_BIT 22
`define PS_HI 20
`define PS_LO 16
`define PS_MAX 5'h14
`define WIN_25 2'h3
`define WIN_37 2'h2
`define WIN_50 2'h1
`define WIN_75 2'h0
`define OPEN_H_SHIFT 1
`define OPEN_Q_SHIFT 2
`define OPEN_E_SHIFT 3
`define OPEN_25_MUL 21'h3
`define OPEN_37_MUL 21'h5
`define DIV_W 16
`define ST_PS_HI 20
`define ST_PS_LO 16
`define CTRL_SW_EN 0
`define CTRL_KICK 1
`define ST_RUN 0
`define ST_TIMEOUT 1
`define ST_WFAULT 2
`define ST_CFG_VALID 3
`define CFG_RESET 32'hffffffff
`define TICK_NS 1000
`define CLK_NS 25
`define TICK_CYCLES (`TICK_NS / `CLK_NS)
`endif
